//--- logic/idlink_pkg.sv
// Shared constants for the single-wire identity link master.
// Assumes a 20 MHz system clock; all link times are counted in microseconds.
package idlink_pkg;

   // Clock and microsecond divider
   localparam int            CLK_HZ     = 20_000_000;
   localparam int            US_CYCLES  = CLK_HZ / 1_000_000;
   localparam int            DIV_W      = 5;
   localparam logic [4:0]    DIV_LAST   = 5'(US_CYCLES - 1);

   // Link times in microseconds, all within the documented windows
   localparam int            US_W                  = 10;
   localparam logic [9:0]    RESET_LOW_TIME        = 10'd500;  // Min 480, plus rise kept under 960
   localparam logic [9:0]    RESET_HIGH_TIME       = 10'd480;  // Quiet time before new activity
   localparam logic [9:0]    PRESENCE_SAMPLE_TIME  = 10'd70;   // Past the 15..60 wait, inside the 60..240 low
   localparam logic [9:0]    WRITE_ONE_LOW_TIME    = 10'd2;    // Window 1..15
   localparam logic [9:0]    WRITE_ZERO_LOW_TIME   = 10'd62;   // Window 60..120
   localparam logic [9:0]    READ_SETUP_TIME       = 10'd2;    // Master low that opens a read slot
   localparam logic [9:0]    READ_SAMPLE_TIME      = 10'd13;   // Just before read_valid_time of 15
   localparam logic [9:0]    SLOT_DURATION         = 10'd70;   // Window 60..120
   localparam logic [9:0]    SLOT_RECOVERY_TIME    = 10'd2;    // Min 1

   // Command port opcodes
   localparam logic [1:0]    OP_RESET   = 2'h0;
   localparam logic [1:0]    OP_WRITE   = 2'h1;
   localparam logic [1:0]    OP_READ    = 2'h2;
   localparam logic [1:0]    OP_TRIPLET = 2'h3;

   // Identity command bytes, sent by the user bit by bit, LSB first
   localparam logic [7:0]    ID_READ_CMD_A = 8'h33;
   localparam logic [7:0]    ID_READ_CMD_B = 8'h0F;
   localparam logic [7:0]    ID_SEARCH_CMD = 8'hF0;

   // Reflected form of x^8 + x^5 + x^4 + 1
   localparam logic [7:0]    CRC_POLY   = 8'h8C;
   localparam logic [7:0]    CRC_INIT   = 8'h00;

   // Triplet step numbers
   localparam logic [1:0]    STEP_BIT   = 2'h0;
   localparam logic [1:0]    STEP_CMP   = 2'h1;
   localparam logic [1:0]    STEP_DIR   = 2'h2;

   typedef enum logic [2:0]
   {
      ST_IDLE      = 3'b000,
      ST_RST_LOW   = 3'b001,
      ST_RST_WAIT  = 3'b010,
      ST_SLOT_LOW  = 3'b011,
      ST_SLOT_REST = 3'b100,
      ST_RECOVER   = 3'b101
   } state_t;

endpackage

//--- logic/idlink_crc8.sv
// Serial CRC-8 accumulator, one bit per shift pulse, LSB first.
// Assumes the caller presents bits in line order and clears before a pass.
`timescale 1ns/1ns
`default_nettype none

module idlink_crc8
(
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   // Control
   input  wire logic        clear_in,
   input  wire logic        shift_in,
   input  wire logic        bit_in,
   // Result
   output logic      [7:0]  crc_out
);

   logic feedback;

   ////////////////////////////////////////////////////////////////////////////
   // Feedback of the reflected shift register
   assign feedback = crc_out[0] ^ bit_in;

   // Clear wins over shift so a new pass starts clean
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
         crc_out <= idlink_pkg::CRC_INIT;
      else if (clear_in)
         crc_out <= idlink_pkg::CRC_INIT;
      else if (shift_in)
         crc_out <= (crc_out >> 1) ^ (feedback ? idlink_pkg::CRC_POLY : idlink_pkg::CRC_INIT);
   end

endmodule // idlink_crc8

`default_nettype wire

//--- logic/idlink_master.sv
// Bus master for a single-wire open-drain identity device link.
// Assumes an external pull-up holds the line high; inputs are synchronous to mclk_in.
//
// How it works
// - User sends the search byte, then issues triplets to walk every slave's identity.
// - Triplet: read bit, read complement, then write the chosen bit value unless both reads are high.
// - Reset holds the line low 500 us, then keeps it released 480 us.
// - Master starts every slot and reset; only presence comes from the slave.
// - Every slot begins with a low, lasts 70 us, then 2 us recovery.
// - Write one is a 2 us low, write zero a 62 us low.
// - Reset low plus rise stays well under 960 us.
// - Master may run CRC-8, polynomial x^8+x^5+x^4+1, over received bits.
// - Transfer is good when the stored last byte matches; running CRC then reads zero.
// - Every bit on the line goes least significant first.
// - Line idles high; master releases it between commands.
`timescale 1ns/1ns
`default_nettype none

module idlink_master
(
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   // Command request
   input  wire logic        cmd_valid_in,
   output logic             cmd_ready_out,
   input  wire logic [1:0]  cmd_op_in,
   input  wire logic        cmd_bit_in,
   input  wire logic        crc_clear_in,
   // Results
   output logic             done_out,
   output logic             presence_out,
   output logic             rx_bit_out,
   output logic             cmp_bit_out,
   output logic             dir_bit_out,
   output logic             no_device_out,
   output logic      [7:0]  crc_out,
   output logic             crc_ok_out,
   // Open-drain line
   input  wire logic        line_in,
   output logic             line_out,
   output logic             line_oe_out
);

   idlink_pkg::state_t state_q;
   logic [idlink_pkg::DIV_W-1:0] div_q;
   logic                         tick;
   logic [idlink_pkg::US_W-1:0]  us_q;
   logic [1:0]                   op_q;
   logic [1:0]                   step_q;
   logic                         wbit_q;
   logic                         reading;
   logic [idlink_pkg::US_W-1:0]  low_len;
   logic                         accept;
   logic                         crc_shift_q;
   logic                         crc_bit_q;

   ////////////////////////////////////////////////////////////////////////////
   // Handshake and slot shape
   assign cmd_ready_out = (state_q == idlink_pkg::ST_IDLE);
   assign accept        = cmd_ready_out & cmd_valid_in;
   assign tick          = (div_q == idlink_pkg::DIV_LAST);
   // Read slots: plain read and the first two triplet steps
   assign reading       = (op_q == idlink_pkg::OP_READ) ||
                          ((op_q == idlink_pkg::OP_TRIPLET) && (step_q != idlink_pkg::STEP_DIR));
   assign low_len       = reading ? idlink_pkg::READ_SETUP_TIME :
                          (wbit_q ? idlink_pkg::WRITE_ONE_LOW_TIME : idlink_pkg::WRITE_ZERO_LOW_TIME);
   // Never drive high; the pull-up does that
   assign line_out      = 1'b0;
   assign crc_ok_out    = (crc_out == idlink_pkg::CRC_INIT);

   ////////////////////////////////////////////////////////////////////////////
   // Microsecond enable, restarted on each accepted command so timing is phase exact
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
         div_q <= '0;
      else if (accept || tick)
         div_q <= '0;
      else
         div_q <= div_q + 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: state, microsecond count and line drive
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         state_q     <= idlink_pkg::ST_IDLE;
         us_q        <= '0;
         op_q        <= idlink_pkg::OP_RESET;
         step_q      <= idlink_pkg::STEP_BIT;
         wbit_q      <= 1'b0;
         line_oe_out <= 1'b0;
      end
      else
      begin
         if (tick)
            us_q <= us_q + 1'b1;
         case (state_q)
            idlink_pkg::ST_IDLE:
            begin
               line_oe_out <= 1'b0;
               if (accept)
               begin
                  op_q        <= cmd_op_in;
                  step_q      <= idlink_pkg::STEP_BIT;
                  wbit_q      <= cmd_bit_in;
                  us_q        <= '0;
                  line_oe_out <= 1'b1;
                  state_q     <= (cmd_op_in == idlink_pkg::OP_RESET) ? idlink_pkg::ST_RST_LOW
                                                                      : idlink_pkg::ST_SLOT_LOW;
               end
            end
            idlink_pkg::ST_RST_LOW:
            begin
               // Held past 480 us but short of 960 us total
               if (tick && (us_q == idlink_pkg::RESET_LOW_TIME - 1'b1))
               begin
                  line_oe_out <= 1'b0;
                  us_q        <= '0;
                  state_q     <= idlink_pkg::ST_RST_WAIT;
               end
            end
            idlink_pkg::ST_RST_WAIT:
            begin
               // Quiet period covers the whole presence window
               if (tick && (us_q == idlink_pkg::RESET_HIGH_TIME - 1'b1))
                  state_q <= idlink_pkg::ST_IDLE;
            end
            idlink_pkg::ST_SLOT_LOW:
            begin
               if (tick && (us_q == low_len - 1'b1))
               begin
                  line_oe_out <= 1'b0;
                  state_q     <= idlink_pkg::ST_SLOT_REST;
               end
            end
            idlink_pkg::ST_SLOT_REST:
            begin
               if (tick && (us_q == idlink_pkg::SLOT_DURATION - 1'b1))
               begin
                  us_q    <= '0;
                  state_q <= idlink_pkg::ST_RECOVER;
               end
            end
            idlink_pkg::ST_RECOVER:
            begin
               if (tick && (us_q == idlink_pkg::SLOT_RECOVERY_TIME - 1'b1))
               begin
                  us_q <= '0;
                  if ((op_q == idlink_pkg::OP_TRIPLET) && (step_q == idlink_pkg::STEP_BIT))
                  begin
                     step_q      <= idlink_pkg::STEP_CMP;
                     line_oe_out <= 1'b1;
                     state_q     <= idlink_pkg::ST_SLOT_LOW;
                  end
                  // Both reads high: nobody left in the search, stop here
                  else if ((op_q == idlink_pkg::OP_TRIPLET) && (step_q == idlink_pkg::STEP_CMP) &&
                           !(rx_bit_out && cmp_bit_out))
                  begin
                     // Differing reads force the bit; a tie takes the user's direction
                     wbit_q      <= (rx_bit_out != cmp_bit_out) ? rx_bit_out : wbit_q;
                     step_q      <= idlink_pkg::STEP_DIR;
                     line_oe_out <= 1'b1;
                     state_q     <= idlink_pkg::ST_SLOT_LOW;
                  end
                  else
                     state_q <= idlink_pkg::ST_IDLE;
               end
            end
            default:
            begin
               line_oe_out <= 1'b0;
               state_q     <= idlink_pkg::ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line sampling: presence and read data
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         presence_out <= 1'b0;
         rx_bit_out   <= 1'b0;
         cmp_bit_out  <= 1'b0;
      end
      else if (accept && (cmd_op_in == idlink_pkg::OP_RESET))
         presence_out <= 1'b0;
      else if (tick && (state_q == idlink_pkg::ST_RST_WAIT) &&
               (us_q == idlink_pkg::PRESENCE_SAMPLE_TIME - 1'b1))
         presence_out <= ~line_in;
      else if (tick && (state_q == idlink_pkg::ST_SLOT_REST) && reading &&
               (us_q == idlink_pkg::READ_SAMPLE_TIME - 1'b1))
      begin
         // Low means a slave held zero; high means nobody drove
         if (step_q == idlink_pkg::STEP_CMP)
            cmp_bit_out <= line_in;
         else
            rx_bit_out  <= line_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Completion pulse, search outcome and CRC feed
   always_ff @(posedge mclk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         done_out      <= 1'b0;
         dir_bit_out   <= 1'b0;
         no_device_out <= 1'b0;
         crc_shift_q   <= 1'b0;
         crc_bit_q     <= 1'b0;
      end
      else
      begin
         done_out    <= 1'b0;
         crc_shift_q <= 1'b0;
         if (accept)
            no_device_out <= 1'b0;
         if (tick && (state_q == idlink_pkg::ST_RST_WAIT) && (us_q == idlink_pkg::RESET_HIGH_TIME - 1'b1))
            done_out <= 1'b1;
         else if (tick && (state_q == idlink_pkg::ST_RECOVER) &&
                  (us_q == idlink_pkg::SLOT_RECOVERY_TIME - 1'b1))
         begin
            // Identity bits arrive LSB first, so the CRC runs in line order
            if (op_q == idlink_pkg::OP_READ)
            begin
               done_out    <= 1'b1;
               crc_shift_q <= 1'b1;
               crc_bit_q   <= rx_bit_out;
            end
            else if (op_q == idlink_pkg::OP_WRITE)
               done_out <= 1'b1;
            else if ((step_q == idlink_pkg::STEP_CMP) && rx_bit_out && cmp_bit_out)
            begin
               done_out      <= 1'b1;
               no_device_out <= 1'b1;
            end
            else if (step_q == idlink_pkg::STEP_DIR)
            begin
               done_out    <= 1'b1;
               dir_bit_out <= wbit_q;
               crc_shift_q <= 1'b1;
               crc_bit_q   <= wbit_q;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // CRC over identity bits; running it over all 64 leaves zero when good
   idlink_crc8 u_crc
   (
      .mclk_in   (mclk_in),
      .reset_in  (reset_in),
      .clear_in  (crc_clear_in),
      .shift_in  (crc_shift_q),
      .bit_in    (crc_bit_q),
      .crc_out   (crc_out)
   );

endmodule // idlink_master

`default_nettype wire

//--- testbench/idlink_props.sv
// Checker on the link master ports: timing of lows, done and crc flag.
// Bound from tb_top; one clock domain, reset_in async active high.
`timescale 1ns/1ns
`default_nettype none
module idlink_props
(
   // Clock, reset and command
   input wire logic       mclk_in,
   input wire logic       reset_in,
   input wire logic       cmd_valid_in,
   input wire logic       cmd_ready_out,
   input wire logic [1:0] cmd_op_in,
   input wire logic       cmd_bit_in,
   input wire logic       crc_clear_in,
   // Results and line
   input wire logic       done_out,
   input wire logic [7:0] crc_out,
   input wire logic       crc_ok_out,
   input wire logic       line_out,
   input wire logic       line_oe_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   bit   [1:0] op_q;
   bit         bit_q;
   int         t_q;
   int         run_q;
   wire        take = cmd_valid_in && cmd_ready_out;
   //////////////////////////////////////////
   // Latched op, cycles since accept, length of each low; no reset needed
   always_ff @(posedge mclk_in)
   begin
      run_q <= line_oe_out ? run_q + 1 : 0;
      t_q   <= take ? 1 : t_q + 1;
      if (take)
      begin
         op_q  <= cmd_op_in;
         bit_q <= cmd_bit_in;
      end
   end
   sequence s_take;
      take;
   endsequence
   sequence s_low_end;
      $fell(line_oe_out);
   endsequence
   a_op_opens_low: assert property (s_take |=> line_oe_out && !cmd_ready_out)
      else $error("op did not open with a low");
   a_reset_low_len: assert property (s_low_end ##0 op_q == 2'h0 |-> run_q == 10000)
      else $error("reset low length wrong");
   a_slot_low_len: assert property (s_low_end ##0 op_q inside {2'h1, 2'h2} |->
      run_q == (op_q == 2'h1 && !bit_q ? 1240 : 40))
      else $error("slot low length wrong");
   a_trip_low_len: assert property (s_low_end ##0 op_q == 2'h3 |-> run_q inside {40, 1240})
      else $error("triplet low length wrong");
   a_reset_done_time: assert property (done_out && op_q == 2'h0 |-> t_q inside {[19601:19602]})
      else $error("reset length wrong");
   a_slot_done_time: assert property (done_out && op_q inside {2'h1, 2'h2} |-> t_q inside {[1441:1442]})
      else $error("slot length wrong");
   a_trip_done_time: assert property (done_out && op_q == 2'h3 |-> t_q inside {[2881:2882], [4321:4322]})
      else $error("triplet length wrong");
   a_done_one_cycle: assert property (done_out |=> !done_out)
      else $error("done longer than a cycle");
   a_idle_released: assert property (cmd_ready_out |-> !line_oe_out && line_out == 1'b0)
      else $error("line held while idle");
   a_crc_ok_match: assert property (crc_clear_in |=> crc_ok_out)
      else $error("crc flag low after clear");
   a_crc_clear: assert property (crc_clear_in |=> crc_out == 8'h00)
      else $error("crc not cleared");
   // The crc may only move right after a result or a clear
   a_crc_feed_time: assert property ($changed(crc_out) |-> $past(done_out) || $past(crc_clear_in))
      else $error("crc moved outside a result");
endmodule // idlink_props
`default_nettype wire

//--- testbench/idlink_slave_model.sv
// Behavioural identity slave on the open-drain line, timed in 50 ns clocks.
// Assumes the bench resolves the wire and feeds it back as line_in.
`timescale 1ns/1ns
`default_nettype none
module idlink_slave_model
#(
   parameter logic [63:0] ID = 64'h0000_0000_0000_0000
)
(
   // Clock and line
   input  wire logic mclk_in,
   input  wire logic line_in,
   // Commanded silence
   input  wire logic absent_in,
   // Open-drain pull
   output logic      pull_low_out
);
   int         lo = 0;
   int         t = 0;
   int         n = 0;
   int         k = 0;
   int         md = 0;  // 0 quiet, 1 reset, 2 presence, 3 command, 4 read, 5 search
   logic       prv = 1'b1;
   logic       sl = 1'b0;
   logic [7:0] cmd = 8'h00;
   wire        fall = prv && !line_in && md != 2;
   //////////////////////////////////////////
   // Replies end at 25 us, well inside the release limit
   assign pull_low_out = !absent_in && ((md == 2 && t >= 600 && t < 2400)
      || (sl && t < 500 && (md == 4 ? !ID[n] : md == 5 && k < 2 && ID[n] == k[0])));
   // Slot timing from each falling edge of the master
   always @(posedge mclk_in)
   begin
      prv <= line_in;
      lo  <= line_in ? 0 : lo + 1;
      t   <= (fall || (md == 1 && line_in)) ? 0 : t + 1;
      if (fall)
         sl <= md > 2;
      if (lo == 9600)
         md <= 1;
      else if (md == 1 && line_in)
         md <= 2;
      else if (md == 2 && t == 2400)
      begin
         md <= 3;
         n  <= 0;
         k  <= 0;
      end
      else if (sl && t == 600)
      begin
         sl <= 1'b0;
         n  <= (md != 5 || k == 2) ? n + 1 : n;
         k  <= (k == 2) ? 0 : k + 1;
         if (md == 3)
            cmd[n] <= line_in;
         if (md == 3 && n == 7)
         begin
            n  <= 0;
            k  <= 0;
            md <= ({line_in, cmd[6:0]} inside {8'h33, 8'h0F}) ? 4 :
                  ({line_in, cmd[6:0]} == 8'hF0) ? 5 : 0;
         end
         if ((md == 4 && n == 63) || (md == 5 && k == 2 && (line_in != ID[n] || n == 63)))
            md <= 0;
      end
   end
endmodule // idlink_slave_model
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench: search, one randomly chosen read command, an empty line.
// Assumes the package, design, slave model and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   function automatic logic [7:0] crc8(input logic [55:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 56; i++)
         c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
      return c;
   endfunction
   // Family 5A and serial values are arbitrary
   localparam logic [55:0] BODY  = 56'h3A70_1234_5678_5A;
   localparam logic [63:0] ID    = {crc8(BODY), BODY};
   // Twin body differs only in bit 0, so the first search step is a tie
   localparam logic [55:0] BODY2 = BODY ^ 56'h1;
   localparam logic [63:0] ID2   = {crc8(BODY2), BODY2};
   logic mclk_in = 1'b0;
   logic reset_in = 1'b1;
   logic cmd_valid_in = 1'b0;
   logic [1:0] cmd_op_in = 2'h0;
   logic cmd_bit_in = 1'b0;
   logic crc_clear_in = 1'b0;
   logic absent = 1'b0;
   logic cmd_ready_out, done_out, presence_out, rx_bit_out, cmp_bit_out, dir_bit_out;
   logic no_device_out, crc_ok_out, line_out, line_oe_out, pull_low, pull_low_b;
   logic [7:0] crc_out;
   // Expected search outcome and which slaves are still in the search
   logic exp_r, exp_c, exp_d, alive_a, alive_b;
   logic [3:0] exp_trip;
   wire  line_w = !((line_oe_out && !line_out) || pull_low || pull_low_b);
   int   err_total = 0;
   int   checks = 0;
   int   mc = 0;
   logic q[$];
   //////////////////////////////////////////
   always #25 mclk_in = !mclk_in;
   idlink_master idlink_master_inst (.mclk_in(mclk_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid_in),
      .cmd_ready_out(cmd_ready_out), .cmd_op_in(cmd_op_in), .cmd_bit_in(cmd_bit_in), .crc_clear_in(crc_clear_in),
      .done_out(done_out), .presence_out(presence_out), .rx_bit_out(rx_bit_out), .cmp_bit_out(cmp_bit_out),
      .dir_bit_out(dir_bit_out), .no_device_out(no_device_out), .crc_out(crc_out), .crc_ok_out(crc_ok_out),
      .line_in(line_w), .line_out(line_out), .line_oe_out(line_oe_out));
   idlink_slave_model #(.ID(ID)) idlink_slave_model_inst (.mclk_in(mclk_in), .line_in(line_w),
      .absent_in(absent), .pull_low_out(pull_low));
   idlink_slave_model #(.ID(ID2)) twin_slave_inst (.mclk_in(mclk_in), .line_in(line_w),
      .absent_in(absent), .pull_low_out(pull_low_b));
   task automatic compare(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Request held from a falling edge until the edge that takes it
   task automatic run(input logic [1:0] op, input logic b);
      int n;
      n = 0;
      @(negedge mclk_in);
      cmd_op_in = op;
      cmd_bit_in = b;
      cmd_valid_in = 1'b1;
      // Ready is read at a falling edge, never in the edge that takes the request
      while (cmd_ready_out !== 1'b1)
         @(negedge mclk_in);
      @(negedge mclk_in);
      cmd_valid_in = 1'b0;
      while (done_out !== 1'b1 && n < 25000)
      begin
         @(negedge mclk_in);
         n++;
      end
      compare(n < 25000, 1'b1, "done missing");
   endtask
   task automatic send(input logic [7:0] v);
      for (int i = 0; i < 8; i++)
         run(idlink_pkg::OP_WRITE, v[i]);
   endtask
   task automatic bus_reset;
      run(idlink_pkg::OP_RESET, 1'($urandom));
      compare(presence_out, !absent, "presence");
   endtask
   // Reference crc kept as an integer, cleared with the design's
   task automatic clear_crc;
      @(negedge mclk_in);
      crc_clear_in = 1'b1;
      @(negedge mclk_in);
      crc_clear_in = 1'b0;
      mc = 0;
   endtask
   task automatic take(input logic b);
      mc = (mc >> 1) ^ (((mc & 1) ^ b) ? 8'h8C : 8'h00);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      // Three resets of 980 us dominate; the tests need about 5.2 ms
      #6_000_000;
      err_total++;
      summarize();
   end
   initial
   begin
      void'($urandom(52));
      repeat (8) @(posedge mclk_in);
      @(negedge mclk_in);
      reset_in = 1'b0;
      bus_reset();
      send(idlink_pkg::ID_SEARCH_CMD);
      clear_crc();
      compare(crc_ok_out, 1'b1, "crc flag clear");
      alive_a = 1'b1;
      alive_b = 1'b1;
      // Wired line: a read is low if any slave still searching pulls it
      for (int i = 0; i < 2; i++)
      begin
         exp_d = 1'($urandom);
         run(idlink_pkg::OP_TRIPLET, exp_d);
         exp_r = (!alive_a || ID[i]) && (!alive_b || ID2[i]);
         exp_c = (!alive_a || !ID[i]) && (!alive_b || !ID2[i]);
         exp_d = (exp_r != exp_c) ? exp_r : exp_d;
         exp_trip = {exp_r, exp_c, exp_d, 1'b0};
         compare({rx_bit_out, cmp_bit_out, dir_bit_out, no_device_out}, exp_trip, "triplet");
         alive_a = alive_a && (ID[i] == exp_d);
         alive_b = alive_b && (ID2[i] == exp_d);
         take(exp_d);
      end
      @(negedge mclk_in);
      compare(crc_out, mc[7:0], "search crc");
      $display("search test finished");
      // Reset cuts the search short; both slaves then answer the read together
      bus_reset();
      send(1'($urandom) ? idlink_pkg::ID_READ_CMD_A : idlink_pkg::ID_READ_CMD_B);
      clear_crc();
      for (int i = 0; i < 8; i++)
         q.push_back(ID[i] & ID2[i]);
      while (q.size() > 0)
      begin
         run(idlink_pkg::OP_READ, 1'($urandom));
         compare(rx_bit_out, q[0], "read bit");
         take(q.pop_front());
      end
      @(negedge mclk_in);
      compare(crc_out, mc[7:0], "read crc");
      compare(crc_ok_out, mc == 0, "crc flag");
      $display("read test finished");
      absent = 1'b1;
      bus_reset();
      run(idlink_pkg::OP_TRIPLET, 1'b0);
      compare({rx_bit_out, cmp_bit_out, no_device_out}, 3'h7, "empty line");
      $display("empty line test finished");
      summarize();
   end
endmodule // tb_top
bind idlink_master idlink_props idlink_props_inst (.mclk_in(mclk_in), .reset_in(reset_in),
   .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_op_in(cmd_op_in), .cmd_bit_in(cmd_bit_in),
   .crc_clear_in(crc_clear_in), .done_out(done_out), .crc_out(crc_out), .crc_ok_out(crc_ok_out),
   .line_out(line_out), .line_oe_out(line_oe_out));
`default_nettype wire
